// [ppl_core.v]
`default_nettype none
`include "ppl_defs.vh"

module ppl_core (
    input  wire        clk_i,
    input  wire        rst_n_i,
    output reg  [8:0]  mem_addr_o,
    output reg         mem_re_o,
    output reg         mem_we_o,
    output wire [31:0] mem_wdata_o,
    input  wire [31:0] mem_rdata_i,
    output wire        hub_req_o,
    output wire        hub_we_o,
    output reg  [15:0] hub_addr_o,
    output wire [31:0] hub_wdata_o,
    input  wire        hub_grant_i,
    input  wire [31:0] hub_rdata_i,
    output reg         retire_o
);
    // ************************************************************
    // One-hot slot states
    // ************************************************************
    localparam [5:0] ST_FETCH = 6'b000001;
    localparam [5:0] ST_WBACK = 6'b000010;
    localparam [5:0] ST_SRC   = 6'b000100;
    localparam [5:0] ST_DST   = 6'b001000;
    localparam [5:0] ST_HWAIT = 6'b010000;
    localparam [5:0] ST_HXFER = 6'b100000;

    reg  [5:0]  state_reg;
    reg  [5:0]  state_next;
    reg  [8:0]  pc_reg;
    reg  [31:0] ir_reg;
    reg         ir_valid_reg;
    reg         fetch_ok_reg;
    reg  [31:0] src_val_reg;
    reg  [31:0] dst_val_reg;
    reg         src_rd_reg;
    reg         dst_rd_reg;
    reg  [31:0] res_reg;
    reg  [8:0]  wb_addr_reg;
    reg         wb_valid_reg;
    reg  [31:0] hub_val_reg;
    reg  [1:0]  hub_cnt_reg;

    wire [31:0] dst_op;
    wire [31:0] alu_result;
    wire        alu_jump;
    wire        alu_cond;
    wire        alu_hub;
    wire        exec;
    wire        squash;
    wire [8:0]  fetch_addr;
    wire        is_imm;

    // Destination data lands one cycle after its read, possibly in a hub wait
    assign dst_op = dst_rd_reg ? mem_rdata_i : dst_val_reg;
    assign is_imm = ir_reg[`PPL_IMM_BIT];

    ppl_alu u_alu (
        .ir_i       (ir_reg),
        .src_i      (src_val_reg),
        .dst_i      (dst_op),
        .ret_addr_i (pc_reg),
        .hub_data_i (hub_val_reg),
        .result_o   (alu_result),
        .jump_o     (alu_jump),
        .cond_o     (alu_cond),
        .hub_o      (alu_hub)
    );

    // ************************************************************
    // Execute and branch resolution
    // ************************************************************
    // Execute overlaps the next fetch in the same cycle
    assign exec = (state_reg == ST_FETCH) && ir_valid_reg;
    // Jump targets are fetched blindly; only a zero count undoes that
    assign fetch_addr = (exec && alu_jump) ? src_val_reg[8:0] : pc_reg;
    assign squash = exec && alu_cond && (alu_result == 32'h00000000);

    // ************************************************************
    // Hub request
    // ************************************************************
    assign hub_req_o   = (state_reg == ST_HWAIT);
    assign hub_we_o    = hub_req_o &&
                         (ir_reg[`PPL_OP_HI:`PPL_OP_LO] == `PPL_OP_HUBWR);
    assign hub_wdata_o = dst_op;
    assign mem_wdata_o = res_reg;

    // ************************************************************
    // Memory port schedule
    // ************************************************************
    always @* begin
        mem_addr_o = 9'h000;
        mem_re_o   = 1'b0;
        mem_we_o   = 1'b0;
        case (state_reg)
            ST_FETCH: begin
                mem_addr_o = fetch_addr;
                mem_re_o   = 1'b1;
            end
            ST_WBACK: begin
                // Writing after the fetch keeps a patched next word unseen
                mem_addr_o = wb_addr_reg;
                mem_we_o   = wb_valid_reg;
            end
            ST_SRC: begin
                mem_addr_o = ir_reg[`PPL_SRC_HI:`PPL_SRC_LO];
                mem_re_o   = ir_valid_reg && !is_imm;
            end
            ST_DST: begin
                mem_addr_o = ir_reg[`PPL_DST_HI:`PPL_DST_LO];
                mem_re_o   = ir_valid_reg;
            end
            default: begin
                mem_addr_o = 9'h000;
            end
        endcase
    end

    // ************************************************************
    // Slot sequencing
    // ************************************************************
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_FETCH: state_next = ST_WBACK;
            ST_WBACK: state_next = ST_SRC;
            ST_SRC:   state_next = ST_DST;
            ST_DST: begin
                // Ordinary slots repeat every four cycles
                if (ir_valid_reg && alu_hub) begin
                    state_next = ST_HWAIT;
                end else begin
                    state_next = ST_FETCH;
                end
            end
            ST_HWAIT: begin
                // Wait may last up to a full hub rotation
                if (hub_grant_i) begin
                    state_next = ST_HXFER;
                end
            end
            ST_HXFER: begin
                if (hub_cnt_reg == `PPL_HUB_LAST) begin
                    state_next = ST_FETCH;
                end
            end
            default: state_next = ST_FETCH;
        endcase
    end

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_reg    <= ST_FETCH;
            pc_reg       <= `PPL_RESET_PC;
            ir_reg       <= 32'h00000000;
            ir_valid_reg <= 1'b0;
            fetch_ok_reg <= 1'b1;
            src_val_reg  <= 32'h00000000;
            dst_val_reg  <= 32'h00000000;
            src_rd_reg   <= 1'b0;
            dst_rd_reg   <= 1'b0;
            res_reg      <= 32'h00000000;
            wb_addr_reg  <= 9'h000;
            wb_valid_reg <= 1'b0;
            hub_val_reg  <= 32'h00000000;
            hub_cnt_reg  <= 2'h0;
            hub_addr_o   <= 16'h0000;
            retire_o     <= 1'b0;
        end else begin
            state_reg  <= state_next;
            src_rd_reg <= (state_reg == ST_SRC) && ir_valid_reg && !is_imm;
            dst_rd_reg <= (state_reg == ST_DST) && ir_valid_reg;
            retire_o   <= exec;
            if (dst_rd_reg) begin
                dst_val_reg <= mem_rdata_i;
            end
            if (state_reg == ST_FETCH) begin
                // Fall-through address survives a mispredict
                if (!squash) begin
                    pc_reg <= fetch_addr + 9'h001;
                end
                fetch_ok_reg <= !squash;
                res_reg      <= alu_result;
                wb_addr_reg  <= ir_reg[`PPL_DST_HI:`PPL_DST_LO];
                wb_valid_reg <= exec && ir_reg[`PPL_WR_BIT];
            end
            if (state_reg == ST_WBACK) begin
                ir_reg       <= mem_rdata_i;
                ir_valid_reg <= fetch_ok_reg;
            end
            // Address follows the source operand so a grant in the first wait cycle sees it
            if ((state_reg == ST_SRC) && is_imm) begin
                src_val_reg <= {23'h000000, ir_reg[`PPL_SRC_HI:`PPL_SRC_LO]};
                hub_addr_o  <= {7'h00, ir_reg[`PPL_SRC_HI:`PPL_SRC_LO]};
            end else if (src_rd_reg) begin
                src_val_reg <= mem_rdata_i;
                hub_addr_o  <= mem_rdata_i[15:0];
            end
            if (state_reg == ST_HWAIT) begin
                hub_cnt_reg <= 2'h0;
                if (hub_grant_i) begin
                    hub_val_reg <= hub_rdata_i;
                end
            end
            if (state_reg == ST_HXFER) begin
                hub_cnt_reg <= hub_cnt_reg + 2'h1;
            end
        end
    end
endmodule

`default_nettype wire

// [ppl_defs.vh]
`ifndef PPL_DEFS_VH
`define PPL_DEFS_VH

// ************************************************************
// Instruction word fields
// ************************************************************
`define PPL_OP_HI      31
`define PPL_OP_LO      26
`define PPL_WR_BIT     23
`define PPL_IMM_BIT    22
`define PPL_DST_HI     17
`define PPL_DST_LO     9
`define PPL_SRC_HI     8
`define PPL_SRC_LO     0

// ************************************************************
// Operation codes
// ************************************************************
`define PPL_OP_MOV     6'h00
`define PPL_OP_ADD     6'h01
`define PPL_OP_SUB     6'h02
`define PPL_OP_AND     6'h03
`define PPL_OP_OR      6'h04
`define PPL_OP_XOR     6'h05
`define PPL_OP_PATCH_I 6'h08
`define PPL_OP_PATCH_S 6'h09
`define PPL_OP_PATCH_D 6'h0a
`define PPL_OP_JSR     6'h10
`define PPL_OP_DECREMENT_BRANCH_NONZERO    6'h11
`define PPL_OP_HUBRD   6'h20
`define PPL_OP_HUBWR   6'h21

// ************************************************************
// Reset values and timing
// ************************************************************
`define PPL_RESET_PC   9'h000
`define PPL_HUB_LAST   2'h1
`define PPL_HUB_PERIOD 16

`endif

// [ppl_alu.v]
`default_nettype none
`include "ppl_defs.vh"

module ppl_alu (
    input  wire [31:0] ir_i,
    input  wire [31:0] src_i,
    input  wire [31:0] dst_i,
    input  wire [8:0]  ret_addr_i,
    input  wire [31:0] hub_data_i,
    output reg  [31:0] result_o,
    output reg         jump_o,
    output reg         cond_o,
    output wire        hub_o
);
    wire [5:0] op;
    assign op    = ir_i[`PPL_OP_HI:`PPL_OP_LO];
    assign hub_o = (op == `PPL_OP_HUBRD) || (op == `PPL_OP_HUBWR);

    // ************************************************************
    // Operation decode and result
    // ************************************************************
    always @* begin
        result_o = src_i;
        jump_o   = 1'b0;
        cond_o   = 1'b0;
        case (op)
            `PPL_OP_ADD:     result_o = dst_i + src_i;
            `PPL_OP_SUB:     result_o = dst_i - src_i;
            `PPL_OP_AND:     result_o = dst_i & src_i;
            `PPL_OP_OR:      result_o = dst_i | src_i;
            `PPL_OP_XOR:     result_o = dst_i ^ src_i;
            `PPL_OP_PATCH_I: result_o = {src_i[8:0], dst_i[22:0]};
            `PPL_OP_PATCH_S: result_o = {dst_i[31:9], src_i[8:0]};
            `PPL_OP_PATCH_D: result_o = {dst_i[31:18], src_i[8:0], dst_i[8:0]};
            `PPL_OP_JSR: begin
                result_o = {dst_i[31:9], ret_addr_i};
                jump_o   = 1'b1;
            end
            `PPL_OP_DECREMENT_BRANCH_NONZERO: begin
                result_o = dst_i - 32'h00000001;
                jump_o   = 1'b1;
                cond_o   = 1'b1;
            end
            `PPL_OP_HUBRD:   result_o = hub_data_i;
            `PPL_OP_HUBWR:   result_o = dst_i;
            default:         result_o = src_i;
        endcase
    end
endmodule

`default_nettype wire

// [ppl_mem_hub.sv]
`default_nettype none
// ****
// Core memory and hub arbiter model
// ****
module ppl_mem_hub (
    input  wire logic        clk_i,
    input  wire logic [3:0]  phase_i,
    input  wire logic [8:0]  mem_addr_i,
    input  wire logic        mem_re_i,
    input  wire logic        mem_we_i,
    input  wire logic [31:0] mem_wdata_i,
    output var  logic [31:0] mem_rdata_o,
    input  wire logic        hub_req_i,
    output logic             hub_grant_o,
    output logic      [31:0] hub_rdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] mem [0:511];
    logic [3:0]  rot = 4'h0;
    always @(posedge clk_i) begin
        rot <= rot + 4'h1;
        if (mem_we_i)
            mem[mem_addr_i] <= mem_wdata_i;
        // Without a read the port flips each cycle between the inverted word and the old word
        mem_rdata_o <= mem_re_i ? mem[mem_addr_i] : ~mem_rdata_o;
    end
    // One window each 16 cycles, granted whether or not a request is up
    assign hub_grant_o = (rot == phase_i);
    assign hub_rdata_o = 32'h5a5ac3c3 ^ {32{~hub_grant_o}};
endmodule
`default_nettype wire

// [ppl_core_asserts.sv]
`default_nettype none
// ****
// Pipeline checker
// ****
module ppl_core_asserts (
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire logic [8:0] mem_addr_o,
    input wire logic       mem_re_o,
    input wire logic       mem_we_o,
    input wire logic       hub_req_o,
    input wire logic       hub_grant_i,
    input wire logic       retire_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    first_fetch_a:
        assert property ($rose(rst_n_i) |-> mem_re_o && mem_addr_o == 9'h000)
        else $error("first fetch not at address zero");
    no_stale_wb_a:
        assert property ($rose(rst_n_i) |-> !mem_we_o ##1 !mem_we_o)
        else $error("write-back in first slot");
    slot_gap_a:
        assert property (retire_o |=> !retire_o [*3])
        else $error("instructions closer than four cycles");
    wb_after_fetch_a:
        assert property (mem_we_o |-> $past(mem_re_o) && !mem_re_o)
        else $error("write-back not right after a fetch");
    exec_fetch_a:
        assert property (retire_o |-> $past(mem_re_o) && !$past(mem_we_o))
        else $error("execute cycle not used for next fetch");
    hub_hold_a:
        assert property (hub_req_o && !hub_grant_i |=> hub_req_o)
        else $error("hub request dropped before grant");
    hub_drop_a:
        assert property (hub_req_o && hub_grant_i |=> !hub_req_o)
        else $error("hub request held after grant");
    hub_finish_a:
        assert property (hub_req_o && hub_grant_i |-> !retire_o [*4] ##1 retire_o)
        else $error("hub instruction not done four cycles after grant");
endmodule
bind ppl_core ppl_core_asserts i_ppl_core_asserts (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .mem_addr_o  (mem_addr_o),
    .mem_re_o    (mem_re_o),
    .mem_we_o    (mem_we_o),
    .hub_req_o   (hub_req_o),
    .hub_grant_i (hub_grant_i),
    .retire_o    (retire_o)
);
`default_nettype wire

// [ppl_core_bench.sv]
`default_nettype none
`include "ppl_defs.vh"
// ****
// Pipeline bench
// ****
module ppl_core_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [3:0]  phase = 4'h0;
    wire  [8:0]  mem_addr;
    wire         mem_re, mem_we, hub_req, hub_we, hub_grant, retire;
    wire  [15:0] hub_addr;
    wire  [31:0] mem_wdata, mem_rdata, hub_wdata, hub_rdata;
    int          bad_count = 0;
    int          checks = 0;
    int          cyc = 0;
    int          rt[$];
    logic [15:0] h_addr = 16'h0000;
    logic        h_we = 1'b0;
    logic [31:0] h_wdata = 32'h00000000;
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (retire === 1'b1)
            rt.push_back(cyc);
        if (hub_req === 1'b1 && hub_grant === 1'b1) begin
            h_addr  <= hub_addr;
            h_we    <= hub_we;
            h_wdata <= hub_wdata;
        end
    end
    ppl_core i_ppl_core (.clk_i(clk_i), .rst_n_i(rst_n_i), .mem_addr_o(mem_addr),
        .mem_re_o(mem_re), .mem_we_o(mem_we), .mem_wdata_o(mem_wdata),
        .mem_rdata_i(mem_rdata), .hub_req_o(hub_req), .hub_we_o(hub_we),
        .hub_addr_o(hub_addr), .hub_wdata_o(hub_wdata), .hub_grant_i(hub_grant),
        .hub_rdata_i(hub_rdata), .retire_o(retire));
    ppl_mem_hub i_ppl_mem_hub (.clk_i(clk_i), .phase_i(phase), .mem_addr_i(mem_addr),
        .mem_re_i(mem_re), .mem_we_i(mem_we), .mem_wdata_i(mem_wdata),
        .mem_rdata_o(mem_rdata), .hub_req_i(hub_req), .hub_grant_o(hub_grant),
        .hub_rdata_o(hub_rdata));
    function automatic logic [31:0] ins(input logic [5:0] op, input logic wr, imm,
                                        input logic [8:0] d, s);
        ins = {op, 2'h0, wr, imm, 4'h0, d, s};
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Program: a move and an add, a patch of the next word, a two-pass loop, three jumps, a hub read and a hub write
    task automatic run_prog(input logic [3:0] ph);
        @(negedge clk_i);
        rst_n_i = 1'b0;
        phase = ph;
        for (int k = 0; k < 512; k++)
            i_ppl_mem_hub.mem[k] = 32'h0;
        i_ppl_mem_hub.mem[0] = ins(`PPL_OP_MOV, 1'b1, 1'b1, 9'h100, 9'h005);
        i_ppl_mem_hub.mem[1] = ins(`PPL_OP_ADD, 1'b1, 1'b1, 9'h100, 9'h003);
        i_ppl_mem_hub.mem[2] = ins(`PPL_OP_PATCH_S, 1'b1, 1'b1, 9'h003, 9'h007);
        i_ppl_mem_hub.mem[3] = ins(`PPL_OP_MOV, 1'b1, 1'b1, 9'h101, 9'h001);
        i_ppl_mem_hub.mem[4] = ins(`PPL_OP_DECREMENT_BRANCH_NONZERO, 1'b1, 1'b1, 9'h102, 9'h004);
        i_ppl_mem_hub.mem[5] = ins(`PPL_OP_JSR, 1'b0, 1'b1, 9'h000, 9'h007);
        i_ppl_mem_hub.mem[6] = ins(`PPL_OP_MOV, 1'b1, 1'b1, 9'h103, 9'h1ff);
        i_ppl_mem_hub.mem[7] = ins(`PPL_OP_HUBRD, 1'b1, 1'b1, 9'h104, 9'h020);
        i_ppl_mem_hub.mem[8] = ins(`PPL_OP_JSR, 1'b0, 1'b1, 9'h000, 9'h00a);
        i_ppl_mem_hub.mem[10] = ins(`PPL_OP_HUBWR, 1'b0, 1'b1, 9'h104, 9'h021);
        i_ppl_mem_hub.mem[11] = ins(`PPL_OP_JSR, 1'b0, 1'b1, 9'h000, 9'h00b);
        h_we = 1'b0;
        i_ppl_mem_hub.mem[9'h102] = 32'h2;
        repeat (12) @(negedge clk_i);
        rt.delete();
        rst_n_i = 1'b1;
        repeat (120) @(negedge clk_i);
        chk("retire count", 32'h1, 32'(rt.size() >= 9));
    endtask
    task automatic test_slots;
        run_prog(4'h0);
        for (int k = 1; k < 6; k++)
            chk("slot gap", 32'h4, 32'(rt[k] - rt[k - 1]));
        chk("not-taken gap", 32'h8, 32'(rt[6] - rt[5]));
        chk("jump gap", 32'h4, 32'(rt[8] - rt[7]));
        chk("sum", 32'h8, i_ppl_mem_hub.mem[9'h100]);
        chk("unpatched run", 32'h1, i_ppl_mem_hub.mem[9'h101]);
        chk("patched word", 32'h7, {23'h0, i_ppl_mem_hub.mem[3][8:0]});
        chk("loop count", 32'h0, i_ppl_mem_hub.mem[9'h102]);
        chk("skipped word", 32'h0, i_ppl_mem_hub.mem[9'h103]);
        $display("test_slots done");
    endtask
    // Two hub phases so that both a short and a long wait for the window occur
    task automatic test_hub;
        for (int p = 0; p < 16; p += 9) begin
            run_prog(4'(p));
            chk("hub span ok", 32'h1, 32'(rt[7] - rt[6] >= 7 && rt[7] - rt[6] <= 22));
            chk("hub data", 32'h5a5ac3c3, i_ppl_mem_hub.mem[9'h104]);
            chk("hub write strobe", 32'h1, {31'h0, h_we});
            chk("hub address", 32'h21, {16'h0, h_addr});
            chk("hub write data", 32'h5a5ac3c3, h_wdata);
        end
        $display("test_hub done");
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clk_i);
        test_slots();
        test_hub();
        complete_run();
    end
    // Three runs of about 135 cycles each; far more than that means a hang
    initial begin
        repeat (1500) @(posedge clk_i);
        bad_count++;
        complete_run();
    end
endmodule
`default_nettype wire
